// >>> sim/motor_model.sv
`timescale 1ns/100ps
module motor_model #(
	parameter int RISE = 4,
	parameter int FALL = 12
) (
	// Clock, reset and drive pulse
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_pulse,
	// Winding current state
	output logic o_reached,
	output logic o_zero
);
	int cnt_reg;
	// Pulses during decay add no new ramp, so the old current decays on its own schedule
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cnt_reg <= 0;
		else if (cnt_reg == 0 && i_pulse)
			cnt_reg <= 1;
		else if (cnt_reg != 0 && cnt_reg < RISE + FALL)
			cnt_reg <= cnt_reg + 1;
		else
			cnt_reg <= 0;
	end
	assign o_reached = (cnt_reg >= RISE);
	assign o_zero = (cnt_reg == 0);
endmodule : motor_model

// >>> sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic I_CLK, I_RST, I_OVERSPEED_DETECT_ENABLE, I_BACKEMF_DETECT_ENABLE, I_ABSENT_DETECT_ENABLE;
	logic I_MOTOR_DRIVING, I_MEAS_RL_ACTIVE, I_MEAS_BACKEMF_ACTIVE, I_POSITION_PULSE_CMD;
	logic I_POSITION_CURRENT_REACHED, I_POSITION_CURRENT_ZERO, I_POSITION_TIMEOUT_FAULT_ENABLE;
	logic I_POSITION_PULSE_RATE_FAULT_ENABLE, I_SLEEP_OR_STANDBY_SELECT, I_SPEED_PIN, I_FAULT_CLEAR;
	logic I_OUTPUT_DISABLE_PIN, O_FAULT_N, O_SHUTDOWN, O_OUTPUTS_HIZ, O_STANDBY, O_SLEEP;
	logic [3:0] I_LOCK_RESPONSE_MODE;
	logic [1:0] I_STARTUP_METHOD, I_STANDBY_HYSTERESIS_SELECT, O_SHUTDOWN_ACTION;
	logic [11:0] I_MOTOR_ABSENT_CURRENT_THRESHOLD;
	logic [15:0] I_OVERSPEED_THRESHOLD, I_BACKEMF_MISMATCH_THRESHOLD, I_SPEED_MEASURED;
	logic [15:0] I_BACKEMF_ESTIMATED, I_BACKEMF_EXPECTED, I_MEASURED_BACKEMF;
	logic [15:0] I_STATIONARY_DETECT_THRESHOLD, I_SPEED_INPUT, I_DIGITAL_SPEED;
	motor_fault_pkg::phase_currents_t I_PHASE_CURRENTS;
	motor_fault_pkg::speed_mode_t I_SPEED_MODE;
	motor_fault_pkg::fault_flags_t O_FAULT_FLAGS;
	motor_fault_pkg::power_ctrl_t O_POWER;
	int error_cnt = 0;
	int checks_done = 0;
	// ----------------------------------------
	// Design and motor
	// ----------------------------------------
	motor_fault_supervisor #(.ABSENT_CYCLES(50), .RETRY_CYCLES(20), .SLEEP_ENTRY_CYCLES(10),
		.WAKE_DETECT_CYCLES(10), .PD_DIV_2(4), .PD_DIV_3(5)) i_motor_fault_supervisor (.*);
	motor_model i_motor_model (.i_clk(I_CLK), .i_rst(I_RST), .i_pulse(I_POSITION_PULSE_CMD),
		.o_reached(I_POSITION_CURRENT_REACHED), .o_zero(I_POSITION_CURRENT_ZERO));
	initial
	begin
		I_CLK = 1'b0;
		forever #2 I_CLK = ~I_CLK;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLK);
		#1;
	endtask : cyc
	task automatic close_out();
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Lock with one response mode, then drop the cause and clear
	task automatic lock_case(input logic [3:0] m, input logic [9:0] f, input logic sd);
		@(posedge I_CLK);
		I_LOCK_RESPONSE_MODE <= m;
		I_SPEED_MEASURED <= 16'h0065;
		cyc(2);
		chk(O_FAULT_FLAGS, f);
		chk(O_SHUTDOWN, sd);
		if (sd)
			chk(O_SHUTDOWN_ACTION, m[1:0]);
		@(posedge I_CLK);
		I_FAULT_CLEAR <= 1'b1;
		cyc(2);
		chk(O_SHUTDOWN, sd);
		I_SPEED_MEASURED <= 16'h0064;
		I_FAULT_CLEAR <= 1'b0;
		cyc(25);
		chk(O_FAULT_FLAGS, (m[3:2] == 2'h1) ? 10'h000 : f);
		I_FAULT_CLEAR <= 1'b1;
		cyc(2);
		chk(O_FAULT_FLAGS, 10'h000);
		I_FAULT_CLEAR <= 1'b0;
	endtask : lock_case
	task automatic t_standby();
		logic [1:0] md [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0};
		logic [1:0] hy [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h2};
		logic [15:0] v [8] = '{16'h0148, 16'h0147, 16'h0148, 16'h0149,
			16'h028f, 16'h0291, 16'h028e, 16'h0290};
		logic e [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		for (int k = 0; k < 8; k++)
		begin
			@(posedge I_CLK);
			I_SPEED_MODE <= motor_fault_pkg::speed_mode_t'(md[k]);
			I_STANDBY_HYSTERESIS_SELECT <= hy[k];
			I_SPEED_INPUT <= v[k];
			I_DIGITAL_SPEED <= v[k];
			cyc(3);
			chk(O_STANDBY, e[k]);
		end
	endtask : t_standby
	task automatic t_sleep();
		@(posedge I_CLK);
		I_SLEEP_OR_STANDBY_SELECT <= 1'b1;
		I_SPEED_MODE <= motor_fault_pkg::SPD_I2C;
		I_DIGITAL_SPEED <= 16'h0000;
		cyc(15);
		chk({O_SLEEP, O_POWER, O_OUTPUTS_HIZ}, 7'h41);
		I_SPEED_PIN <= 1'b1;
		cyc(15);
		chk({O_SLEEP, O_POWER}, 6'h1f);
	endtask : t_sleep
	// Back-EMF, absent-motor and back-EMF measurement faults reported, then cleared
	task automatic t_locks();
		@(posedge I_CLK);
		I_LOCK_RESPONSE_MODE <= 4'h8;
		{I_BACKEMF_DETECT_ENABLE, I_ABSENT_DETECT_ENABLE, I_MEAS_BACKEMF_ACTIVE} <= 3'h7;
		{I_BACKEMF_ESTIMATED, I_BACKEMF_EXPECTED, I_BACKEMF_MISMATCH_THRESHOLD} <= 48'h0031_0020_0010;
		{I_MEASURED_BACKEMF, I_STATIONARY_DETECT_THRESHOLD} <= 32'h001f_0020;
		I_MOTOR_ABSENT_CURRENT_THRESHOLD <= 12'h040;
		I_PHASE_CURRENTS <= 36'h100_03f_100;
		cyc(2);
		chk({O_FAULT_FLAGS, O_FAULT_N}, 11'h690);
		I_MEAS_BACKEMF_ACTIVE <= 1'b0;
		cyc(48);
		chk(O_FAULT_FLAGS, 10'h348);
		cyc(1);
		chk(O_FAULT_FLAGS, 10'h368);
		{I_BACKEMF_DETECT_ENABLE, I_ABSENT_DETECT_ENABLE, I_FAULT_CLEAR} <= 3'h1;
		cyc(2);
		chk({O_FAULT_FLAGS, O_FAULT_N}, 11'h001);
		I_FAULT_CLEAR <= 1'b0;
	endtask : t_locks
	task automatic t_pulse_rate();
		@(posedge I_CLK);
		I_STARTUP_METHOD <= 2'h2;
		I_POSITION_PULSE_RATE_FAULT_ENABLE <= 1'b1;
		I_POSITION_PULSE_CMD <= 1'b1;
		@(posedge I_CLK);
		I_POSITION_PULSE_CMD <= 1'b0;
		cyc(8);
		chk(O_FAULT_FLAGS, 10'h000);
		I_POSITION_PULSE_CMD <= 1'b1;
		@(posedge I_CLK);
		I_POSITION_PULSE_CMD <= 1'b0;
		cyc(2);
		chk(O_FAULT_FLAGS.position_pulse_rate_fault, 1'b1);
	endtask : t_pulse_rate
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{I_OVERSPEED_DETECT_ENABLE, I_BACKEMF_DETECT_ENABLE, I_ABSENT_DETECT_ENABLE,
			I_MOTOR_DRIVING, I_MEAS_RL_ACTIVE, I_MEAS_BACKEMF_ACTIVE, I_POSITION_PULSE_CMD,
			I_POSITION_TIMEOUT_FAULT_ENABLE, I_POSITION_PULSE_RATE_FAULT_ENABLE,
			I_SLEEP_OR_STANDBY_SELECT, I_SPEED_PIN, I_FAULT_CLEAR, I_OUTPUT_DISABLE_PIN,
			I_LOCK_RESPONSE_MODE, I_STARTUP_METHOD, I_STANDBY_HYSTERESIS_SELECT,
			I_MOTOR_ABSENT_CURRENT_THRESHOLD, I_BACKEMF_MISMATCH_THRESHOLD, I_SPEED_MEASURED,
			I_BACKEMF_ESTIMATED, I_BACKEMF_EXPECTED, I_MEASURED_BACKEMF,
			I_STATIONARY_DETECT_THRESHOLD, I_PHASE_CURRENTS} = '0;
		I_SPEED_MODE = motor_fault_pkg::SPD_ANALOG;
		{I_OVERSPEED_THRESHOLD, I_SPEED_INPUT, I_DIGITAL_SPEED} = {3{16'h0064}} | 48'h0000_ffff_ffff;
		I_RST = 1'b1;
		repeat (10) @(posedge I_CLK);
		I_RST <= 1'b0;
		cyc(2);
		chk({O_FAULT_FLAGS, O_FAULT_N, O_STANDBY, O_SLEEP}, 13'h004);
		chk(O_POWER, 5'h1f);
		I_OVERSPEED_DETECT_ENABLE <= 1'b1;
		I_SPEED_MEASURED <= 16'h0065;
		cyc(3);
		chk(O_FAULT_FLAGS, 10'h000);
		I_MOTOR_DRIVING <= 1'b1;
		I_OVERSPEED_DETECT_ENABLE <= 1'b0;
		cyc(3);
		chk(O_FAULT_FLAGS, 10'h000);
		I_OVERSPEED_DETECT_ENABLE <= 1'b1;
		I_SPEED_MEASURED <= 16'h0064;
		lock_case(4'h0, 10'h380, 1'b1);
		lock_case(4'h3, 10'h380, 1'b1);
		lock_case(4'h6, 10'h380, 1'b1);
		lock_case(4'h8, 10'h380, 1'b0);
		lock_case(4'h9, 10'h000, 1'b0);
		I_OUTPUT_DISABLE_PIN <= 1'b1;
		cyc(2);
		chk(O_OUTPUTS_HIZ, 1'b1);
		I_OUTPUT_DISABLE_PIN <= 1'b0;
		t_locks();
		t_pulse_rate();
		t_standby();
		t_sleep();
		close_out();
	end
	initial
	begin
		#20000;
		error_cnt++;
		close_out();
	end
endmodule : tb_top

// >>> verilog/hold_counter.sv
`timescale 1ns/100ps
module hold_counter #(
	parameter int unsigned W = 32,
	parameter logic [31:0] LIMIT = 32'h0000_0001
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Condition and result
	input wire logic i_cond,
	output logic o_hit
);
	typedef struct packed {
		logic [W-1:0] count;
		logic hit;
	} hold_state_t;
	hold_state_t state_reg;
	hold_state_t state_next;

	// Any gap in the condition restarts the whole wait
	always_comb
	begin
		state_next = state_reg;
		if (!i_cond)
			state_next.count = '0;
		else if (state_reg.count != LIMIT[W-1:0])
			state_next.count = state_reg.count + 1'b1;
		state_next.hit = i_cond && (state_next.count == LIMIT[W-1:0]);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign o_hit = state_reg.hit;
endmodule : hold_counter

// >>> verilog/motor_fault_pkg.sv
// Overview of operation
// - Each lock detector has its own enable input and can be switched off alone.
// - Overspeed lock fires when measured speed exceeds threshold, then mode response applies.
// - Back-EMF lock fires when estimate and expectation differ beyond threshold.
// - Absent-motor lock fires when a phase current stays low for 500 ms.
// - Resistance/inductance measurement flags a fault when the ramp-up timer overflows.
// - Back-EMF constant measurement flags a fault when back-EMF is below stationary threshold.
// - Position detect start-up (code 10b) times ramps with 12-bit timers.
// - Ramp timing starts at 10 MHz and retries at 1 MHz, 100 kHz, 10 kHz.
// - Ramp-up timeout fault after overflow at all four timer rates.
// - Ramp-down uses same sequence; timeout fault when decay fails all four times.
// - Position timer timeout faults are reported only when their enable is set.
// - Pulse-rate fault when a new pulse comes before previous current decayed.
// - Sleep select uses sleep: drivers, sense, regulators, pump and I2C off.
// - Standby select keeps pump, regulators and I2C on while motor waits stopped.
// - Analog, duty and frequency inputs use 1% or 2% standby threshold by hysteresis.
// - Digital speed input uses standby threshold 328 or 656 by hysteresis.
// - Standby entered below the selected threshold and left above that same threshold.
// - Sleep only in digital mode: zero command and low pin enter, high pin wakes.
// - Latched fault holds shutdown until condition gone and host writes fault clear.
// - Output disable pin forces all six output transistors to high impedance.
// - Detectors keep running while outputs are disabled, so locks may report.
// - Mode 00xx latched, 01xx auto retry, 1000 report only, 1xx1 no action.
// - Any lock outside no-action mode sets controller fault, motor lock and the specific lock flag.
package motor_fault_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int PD_TIMER_W = 12;
	localparam int PD_HZ_0 = 10_000_000;
	localparam int PD_HZ_1 = 1_000_000;
	localparam int PD_HZ_2 = 100_000;
	localparam int PD_HZ_3 = 10_000;
	localparam int PD_DIV_0 = CLK_HZ / PD_HZ_0;
	localparam int PD_DIV_1 = CLK_HZ / PD_HZ_1;
	localparam int PD_DIV_2 = CLK_HZ / PD_HZ_2;
	localparam int PD_DIV_3 = CLK_HZ / PD_HZ_3;
	localparam int ABSENT_TIME_MS = 500;
	localparam int ABSENT_CYCLES = CLK_HZ / 1000 * ABSENT_TIME_MS;
	localparam int RETRY_TIME_MS = 100;
	localparam int RETRY_CYCLES = CLK_HZ / 1000 * RETRY_TIME_MS;
	localparam int SLEEP_ENTRY_TIME_MS = 1;
	localparam int SLEEP_ENTRY_CYCLES = CLK_HZ / 1000 * SLEEP_ENTRY_TIME_MS;
	localparam int WAKE_DETECT_TIME_MS = 1;
	localparam int WAKE_DETECT_CYCLES = CLK_HZ / 1000 * WAKE_DETECT_TIME_MS;
	// ----------------------------------------
	// Codes and thresholds
	// ----------------------------------------
	localparam logic [1:0] STARTUP_POSITION = 2'h2;
	localparam logic [1:0] HYST_WIDE = 2'h3;
	localparam int SPEED_FS = 65535;
	localparam int STANDBY_PCT_NARROW = 1;
	localparam int STANDBY_PCT_WIDE = 2;
	localparam logic [15:0] STANDBY_THR_NARROW = 16'(SPEED_FS * STANDBY_PCT_NARROW / 100);
	localparam logic [15:0] STANDBY_THR_WIDE = 16'(SPEED_FS * STANDBY_PCT_WIDE / 100);
	localparam logic [15:0] I2C_THR_NARROW = 16'h0148;
	localparam logic [15:0] I2C_THR_WIDE = 16'h0290;
	localparam int LOCK_MODE_NOACT_BIT = 0;
	localparam int LOCK_MODE_CLASS_LSB = 2;
	localparam logic [1:0] LOCK_CLASS_LATCHED = 2'h0;
	localparam logic [1:0] LOCK_CLASS_AUTO = 2'h1;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPD_ANALOG = 2'h0,
		SPD_PWM = 2'h1,
		SPD_FREQ = 2'h2,
		SPD_I2C = 2'h3
	} speed_mode_t;
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_STANDBY = 2'h1,
		PWR_SLEEP = 2'h3
	} power_state_t;
	typedef struct packed {
		logic [11:0] a;
		logic [11:0] b;
		logic [11:0] c;
	} phase_currents_t;
	typedef struct packed {
		logic controller_fault;
		logic motor_lock_flag;
		logic overspeed_lock;
		logic backemf_mismatch_lock;
		logic motor_absent_event;
		logic measurement_position_fault;
		logic measurement_backemf_fault;
		logic rampup_timeout_fault;
		logic rampdown_timeout_fault;
		logic position_pulse_rate_fault;
	} fault_flags_t;
	typedef struct packed {
		logic mosfets;
		logic sense_amps;
		logic regulators;
		logic charge_pump;
		logic i2c;
	} power_ctrl_t;
	typedef struct packed {
		power_state_t pwr;
		fault_flags_t flags;
		logic shutdown;
		logic [1:0] action;
		logic hiz;
		power_ctrl_t power;
		logic fault_n;
		logic standby;
		logic sleep;
	} sup_state_t;
endpackage : motor_fault_pkg

// >>> verilog/motor_fault_supervisor.sv
`timescale 1ns/100ps
module motor_fault_supervisor #(
	parameter int unsigned ABSENT_CYCLES = motor_fault_pkg::ABSENT_CYCLES,
	parameter int unsigned RETRY_CYCLES = motor_fault_pkg::RETRY_CYCLES,
	parameter int unsigned SLEEP_ENTRY_CYCLES = motor_fault_pkg::SLEEP_ENTRY_CYCLES,
	parameter int unsigned WAKE_DETECT_CYCLES = motor_fault_pkg::WAKE_DETECT_CYCLES,
	parameter int unsigned PD_DIV_2 = motor_fault_pkg::PD_DIV_2,
	parameter int unsigned PD_DIV_3 = motor_fault_pkg::PD_DIV_3
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Lock detector configuration
	input wire logic I_OVERSPEED_DETECT_ENABLE,
	input wire logic I_BACKEMF_DETECT_ENABLE,
	input wire logic I_ABSENT_DETECT_ENABLE,
	input wire logic [3:0] I_LOCK_RESPONSE_MODE,
	input wire logic [15:0] I_OVERSPEED_THRESHOLD,
	input wire logic [15:0] I_BACKEMF_MISMATCH_THRESHOLD,
	input wire logic [11:0] I_MOTOR_ABSENT_CURRENT_THRESHOLD,
	// Motor observations
	input wire logic I_MOTOR_DRIVING,
	input wire logic [15:0] I_SPEED_MEASURED,
	input wire logic [15:0] I_BACKEMF_ESTIMATED,
	input wire logic [15:0] I_BACKEMF_EXPECTED,
	input wire motor_fault_pkg::phase_currents_t I_PHASE_CURRENTS,
	// Parameter measurement
	input wire logic I_MEAS_RL_ACTIVE,
	input wire logic I_MEAS_BACKEMF_ACTIVE,
	input wire logic [15:0] I_MEASURED_BACKEMF,
	input wire logic [15:0] I_STATIONARY_DETECT_THRESHOLD,
	// Initial position detect
	input wire logic [1:0] I_STARTUP_METHOD,
	input wire logic I_POSITION_PULSE_CMD,
	input wire logic I_POSITION_CURRENT_REACHED,
	input wire logic I_POSITION_CURRENT_ZERO,
	input wire logic I_POSITION_TIMEOUT_FAULT_ENABLE,
	input wire logic I_POSITION_PULSE_RATE_FAULT_ENABLE,
	// Power modes
	input wire logic I_SLEEP_OR_STANDBY_SELECT,
	input wire motor_fault_pkg::speed_mode_t I_SPEED_MODE,
	input wire logic [1:0] I_STANDBY_HYSTERESIS_SELECT,
	input wire logic [15:0] I_SPEED_INPUT,
	input wire logic [15:0] I_DIGITAL_SPEED,
	input wire logic I_SPEED_PIN,
	// Host controls
	input wire logic I_FAULT_CLEAR,
	input wire logic I_OUTPUT_DISABLE_PIN,
	// Fault status
	output motor_fault_pkg::fault_flags_t O_FAULT_FLAGS,
	output logic O_FAULT_N,
	// Output stage and power
	output logic O_SHUTDOWN,
	output logic [1:0] O_SHUTDOWN_ACTION,
	output logic O_OUTPUTS_HIZ,
	output motor_fault_pkg::power_ctrl_t O_POWER,
	output logic O_STANDBY,
	output logic O_SLEEP
);
	motor_fault_pkg::sup_state_t st_reg;
	motor_fault_pkg::sup_state_t st_next;

	// ----------------------------------------
	// Lock detection
	// ----------------------------------------
	logic detect_on;
	logic overspeed_hit;
	logic backemf_hit;
	logic absent_low;
	logic absent_hit;
	logic lock_cond;
	logic [15:0] backemf_diff;
	logic [1:0] mode_class;
	logic mode_noact;
	logic mode_latched;
	logic mode_auto;
	logic retry_hit;

	// Outputs disabled by pin do not stop detection, so locks may still fire
	assign detect_on = I_MOTOR_DRIVING && (st_reg.pwr == motor_fault_pkg::PWR_RUN);
	assign overspeed_hit = detect_on && I_OVERSPEED_DETECT_ENABLE
		&& (I_SPEED_MEASURED > I_OVERSPEED_THRESHOLD);
	assign backemf_diff = (I_BACKEMF_ESTIMATED > I_BACKEMF_EXPECTED)
		? I_BACKEMF_ESTIMATED - I_BACKEMF_EXPECTED
		: I_BACKEMF_EXPECTED - I_BACKEMF_ESTIMATED;
	assign backemf_hit = detect_on && I_BACKEMF_DETECT_ENABLE
		&& (backemf_diff > I_BACKEMF_MISMATCH_THRESHOLD);
	assign absent_low = (I_PHASE_CURRENTS.a < I_MOTOR_ABSENT_CURRENT_THRESHOLD)
		|| (I_PHASE_CURRENTS.b < I_MOTOR_ABSENT_CURRENT_THRESHOLD)
		|| (I_PHASE_CURRENTS.c < I_MOTOR_ABSENT_CURRENT_THRESHOLD);

	// Any gap in the low current restarts the 500 ms wait
	hold_counter #(
		.W(32),
		.LIMIT(ABSENT_CYCLES)
	) u_absent_hold (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_cond(detect_on && I_ABSENT_DETECT_ENABLE && absent_low),
		.o_hit(absent_hit)
	);

	assign lock_cond = overspeed_hit || backemf_hit || absent_hit;
	assign mode_class = I_LOCK_RESPONSE_MODE[motor_fault_pkg::LOCK_MODE_CLASS_LSB +: 2];
	assign mode_noact = I_LOCK_RESPONSE_MODE[3] && I_LOCK_RESPONSE_MODE[motor_fault_pkg::LOCK_MODE_NOACT_BIT];
	assign mode_latched = (mode_class == motor_fault_pkg::LOCK_CLASS_LATCHED);
	assign mode_auto = (mode_class == motor_fault_pkg::LOCK_CLASS_AUTO);

	hold_counter #(
		.W(32),
		.LIMIT(RETRY_CYCLES)
	) u_retry_hold (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_cond(st_reg.shutdown && mode_auto),
		.o_hit(retry_hit)
	);

	// ----------------------------------------
	// Initial position detect timers
	// ----------------------------------------
	logic pd_allowed;
	logic up_busy;
	logic up_done;
	logic up_fail;
	logic down_busy;
	logic down_fail;
	logic pulse_too_soon;

	assign pd_allowed = (I_STARTUP_METHOD == motor_fault_pkg::STARTUP_POSITION)
		|| I_MEAS_RL_ACTIVE;
	assign pulse_too_soon = I_POSITION_PULSE_CMD && down_busy;

	position_ramp_timer #(
		.TW(motor_fault_pkg::PD_TIMER_W),
		.D0(motor_fault_pkg::PD_DIV_0),
		.D1(motor_fault_pkg::PD_DIV_1),
		.D2(PD_DIV_2),
		.D3(PD_DIV_3)
	) u_rampup (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_start(I_POSITION_PULSE_CMD && pd_allowed && !up_busy && !down_busy),
		.i_reached(I_POSITION_CURRENT_REACHED),
		.o_busy(up_busy),
		.o_done(up_done),
		.o_fail(up_fail)
	);

	// Decay timing follows a successful ramp-up with the same rate sequence
	position_ramp_timer #(
		.TW(motor_fault_pkg::PD_TIMER_W),
		.D0(motor_fault_pkg::PD_DIV_0),
		.D1(motor_fault_pkg::PD_DIV_1),
		.D2(PD_DIV_2),
		.D3(PD_DIV_3)
	) u_rampdown (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_start(up_done),
		.i_reached(I_POSITION_CURRENT_ZERO),
		.o_busy(down_busy),
		.o_done(),
		.o_fail(down_fail)
	);

	// ----------------------------------------
	// Power mode thresholds
	// ----------------------------------------
	logic wide_hyst;
	logic [15:0] active_speed;
	logic [15:0] standby_thr;
	logic sleep_path;
	logic sleep_in_hit;
	logic wake_hit;

	assign wide_hyst = (I_STANDBY_HYSTERESIS_SELECT == motor_fault_pkg::HYST_WIDE);
	assign active_speed = (I_SPEED_MODE == motor_fault_pkg::SPD_I2C) ? I_DIGITAL_SPEED : I_SPEED_INPUT;
	always_comb
	begin
		if (I_SPEED_MODE == motor_fault_pkg::SPD_I2C)
			standby_thr = wide_hyst ? motor_fault_pkg::I2C_THR_WIDE
				: motor_fault_pkg::I2C_THR_NARROW;
		else
			standby_thr = wide_hyst ? motor_fault_pkg::STANDBY_THR_WIDE
				: motor_fault_pkg::STANDBY_THR_NARROW;
	end
	// Sleep exists only with the digital speed input; other inputs fall back to standby
	assign sleep_path = I_SLEEP_OR_STANDBY_SELECT && (I_SPEED_MODE == motor_fault_pkg::SPD_I2C);

	hold_counter #(
		.W(32),
		.LIMIT(SLEEP_ENTRY_CYCLES)
	) u_sleep_hold (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_cond((st_reg.pwr != motor_fault_pkg::PWR_SLEEP) && sleep_path
			&& (I_DIGITAL_SPEED == 16'h0000) && !I_SPEED_PIN),
		.o_hit(sleep_in_hit)
	);

	hold_counter #(
		.W(32),
		.LIMIT(WAKE_DETECT_CYCLES)
	) u_wake_hold (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_cond((st_reg.pwr == motor_fault_pkg::PWR_SLEEP) && I_SPEED_PIN),
		.o_hit(wake_hit)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		// Clearing is evaluated first so that a new event in the same cycle wins
		if (I_FAULT_CLEAR && !lock_cond && !mode_auto)
		begin
			st_next.flags = '0;
			st_next.shutdown = 1'b0;
		end
		if (retry_hit)
		begin
			st_next.flags.motor_lock_flag = 1'b0;
			st_next.flags.overspeed_lock = 1'b0;
			st_next.flags.backemf_mismatch_lock = 1'b0;
			st_next.flags.motor_absent_event = 1'b0;
			st_next.shutdown = 1'b0;
		end
		if (lock_cond && !mode_noact)
		begin
			st_next.flags.motor_lock_flag = 1'b1;
			if (overspeed_hit)
				st_next.flags.overspeed_lock = 1'b1;
			if (backemf_hit)
				st_next.flags.backemf_mismatch_lock = 1'b1;
			if (absent_hit)
				st_next.flags.motor_absent_event = 1'b1;
			if (mode_latched || mode_auto)
			begin
				st_next.shutdown = 1'b1;
				st_next.action = I_LOCK_RESPONSE_MODE[1:0];
			end
		end
		if (up_fail && I_MEAS_RL_ACTIVE)
			st_next.flags.measurement_position_fault = 1'b1;
		if (up_fail && !I_MEAS_RL_ACTIVE && I_POSITION_TIMEOUT_FAULT_ENABLE)
			st_next.flags.rampup_timeout_fault = 1'b1;
		if (down_fail && !I_MEAS_RL_ACTIVE && I_POSITION_TIMEOUT_FAULT_ENABLE)
			st_next.flags.rampdown_timeout_fault = 1'b1;
		if (pulse_too_soon && I_POSITION_PULSE_RATE_FAULT_ENABLE)
			st_next.flags.position_pulse_rate_fault = 1'b1;
		if (I_MEAS_BACKEMF_ACTIVE && (I_MEASURED_BACKEMF < I_STATIONARY_DETECT_THRESHOLD))
			st_next.flags.measurement_backemf_fault = 1'b1;
		st_next.flags.controller_fault = st_next.flags.motor_lock_flag
			|| st_next.flags.measurement_position_fault
			|| st_next.flags.measurement_backemf_fault
			|| st_next.flags.rampup_timeout_fault
			|| st_next.flags.rampdown_timeout_fault
			|| st_next.flags.position_pulse_rate_fault;

		unique case (st_reg.pwr)
			motor_fault_pkg::PWR_RUN:
			begin
				if (sleep_path)
				begin
					if (sleep_in_hit)
						st_next.pwr = motor_fault_pkg::PWR_SLEEP;
				end
				else if (active_speed < standby_thr)
					st_next.pwr = motor_fault_pkg::PWR_STANDBY;
			end
			motor_fault_pkg::PWR_STANDBY:
			begin
				if (sleep_path || (active_speed > standby_thr))
					st_next.pwr = motor_fault_pkg::PWR_RUN;
			end
			motor_fault_pkg::PWR_SLEEP:
			begin
				if (wake_hit)
					st_next.pwr = motor_fault_pkg::PWR_RUN;
			end
			default: st_next.pwr = motor_fault_pkg::PWR_RUN;
		endcase

		// Sleep drops every supply; standby keeps supplies but stops the bridge
		st_next.power.mosfets = (st_next.pwr == motor_fault_pkg::PWR_RUN);
		st_next.power.sense_amps = (st_next.pwr != motor_fault_pkg::PWR_SLEEP);
		st_next.power.regulators = (st_next.pwr != motor_fault_pkg::PWR_SLEEP);
		st_next.power.charge_pump = (st_next.pwr != motor_fault_pkg::PWR_SLEEP);
		st_next.power.i2c = (st_next.pwr != motor_fault_pkg::PWR_SLEEP);
		st_next.hiz = I_OUTPUT_DISABLE_PIN || (st_next.pwr == motor_fault_pkg::PWR_SLEEP);
		st_next.fault_n = !st_next.flags.controller_fault;
		st_next.standby = (st_next.pwr == motor_fault_pkg::PWR_STANDBY);
		st_next.sleep = (st_next.pwr == motor_fault_pkg::PWR_SLEEP);
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			st_reg <= '{pwr: motor_fault_pkg::PWR_RUN, flags: '0, shutdown: 1'b0,
				action: 2'h0, hiz: 1'b0, power: 5'h1f, fault_n: 1'b1, standby: 1'b0, sleep: 1'b0};
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_FAULT_FLAGS = st_reg.flags;
	assign O_FAULT_N = st_reg.fault_n;
	assign O_SHUTDOWN = st_reg.shutdown;
	assign O_SHUTDOWN_ACTION = st_reg.action;
	assign O_OUTPUTS_HIZ = st_reg.hiz;
	assign O_POWER = st_reg.power;
	assign O_STANDBY = st_reg.standby;
	assign O_SLEEP = st_reg.sleep;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	sequence s_latched_lock;
		O_SHUTDOWN && mode_latched && !I_FAULT_CLEAR;
	endsequence
	sequence s_clean_clear;
		I_FAULT_CLEAR && !lock_cond && !mode_auto;
	endsequence

	a_disable_forces_hiz: assert property (I_OUTPUT_DISABLE_PIN |=> O_OUTPUTS_HIZ)
		else $error("output disable did not float outputs");
	a_overspeed_enable_gate: assert property ($rose(O_FAULT_FLAGS.overspeed_lock)
		|-> $past(I_OVERSPEED_DETECT_ENABLE) && $past(detect_on))
		else $error("overspeed lock without enable");
	a_lock_sets_flags: assert property (overspeed_hit && !mode_noact |=> O_FAULT_FLAGS.overspeed_lock
		&& O_FAULT_FLAGS.motor_lock_flag && !O_FAULT_N)
		else $error("lock flags not set");
	a_latched_holds: assert property (s_latched_lock |=> O_SHUTDOWN)
		else $error("latched shutdown released without clear");
	a_clear_releases: assert property (s_clean_clear ##0 !(lock_cond && !mode_noact)
		|=> !O_SHUTDOWN && !O_FAULT_FLAGS.motor_lock_flag)
		else $error("fault clear ignored");
	a_timeout_gated: assert property ($rose(O_FAULT_FLAGS.rampup_timeout_fault)
		|-> $past(I_POSITION_TIMEOUT_FAULT_ENABLE) && $past(up_fail))
		else $error("ramp-up timeout reported while disabled");
	a_pulse_rate_flag: assert property (pulse_too_soon && I_POSITION_PULSE_RATE_FAULT_ENABLE
		|=> O_FAULT_FLAGS.position_pulse_rate_fault)
		else $error("pulse rate fault missed");
	a_i2c_standby_enter: assert property (!O_STANDBY && !O_SLEEP && !sleep_path
		&& (I_SPEED_MODE == motor_fault_pkg::SPD_I2C) && (I_DIGITAL_SPEED < standby_thr)
		|=> O_STANDBY)
		else $error("standby not entered");
	a_sleep_supplies_off: assert property ($rose(O_SLEEP)
		|-> !O_POWER.charge_pump && !O_POWER.i2c && O_OUTPUTS_HIZ ##1 O_SLEEP [*1])
		else $error("supplies left on in sleep");
	a_meas_backemf_flag: assert property (I_MEAS_BACKEMF_ACTIVE
		&& (I_MEASURED_BACKEMF < I_STATIONARY_DETECT_THRESHOLD)
		|=> O_FAULT_FLAGS.measurement_backemf_fault)
		else $error("measurement back-EMF fault missed");
endmodule : motor_fault_supervisor

// >>> verilog/position_ramp_timer.sv
`timescale 1ns/100ps
module position_ramp_timer #(
	parameter int unsigned TW = 12,
	parameter int unsigned D0 = 25,
	parameter int unsigned D1 = 250,
	parameter int unsigned D2 = 2500,
	parameter int unsigned D3 = 25000
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_start,
	input wire logic i_reached,
	// Status
	output logic o_busy,
	output logic o_done,
	output logic o_fail
);
	typedef struct packed {
		logic busy;
		logic [1:0] stage;
		logic [15:0] pre;
		logic [TW-1:0] timer;
		logic done;
		logic fail;
	} ramp_state_t;
	ramp_state_t state_reg;
	ramp_state_t state_next;
	logic [15:0] div_last;

	always_comb
	begin
		unique case (state_reg.stage)
			2'h0: div_last = 16'(D0 - 1);
			2'h1: div_last = 16'(D1 - 1);
			2'h2: div_last = 16'(D2 - 1);
			2'h3: div_last = 16'(D3 - 1);
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.done = 1'b0;
		state_next.fail = 1'b0;
		if (!state_reg.busy)
		begin
			if (i_start)
			begin
				state_next.busy = 1'b1;
				state_next.stage = 2'h0;
				state_next.pre = '0;
				state_next.timer = '0;
			end
		end
		else if (i_reached)
		begin
			state_next.busy = 1'b0;
			state_next.done = 1'b1;
		end
		else if (state_reg.pre == div_last)
		begin
			state_next.pre = '0;
			// Overflow: retry at the next slower rate, give up after the last
			if (&state_reg.timer)
			begin
				state_next.timer = '0;
				if (state_reg.stage == 2'h3)
				begin
					state_next.busy = 1'b0;
					state_next.fail = 1'b1;
				end
				else
					state_next.stage = state_reg.stage + 2'h1;
			end
			else
				state_next.timer = state_reg.timer + 1'b1;
		end
		else
			state_next.pre = state_reg.pre + 16'h0001;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign o_busy = state_reg.busy;
	assign o_done = state_reg.done;
	assign o_fail = state_reg.fail;
endmodule : position_ramp_timer
